// file: hdl/pcrs_pkg.sv
// constants and types for the program counter and return stack
// Summary of operation
// - 13-bit counter; low byte is a register software reads and writes.
// - counter bits 12..8 never software-visible; software writes them only through the high latch.
// - every reset clears the whole counter.
// - low-byte write loads counter bits 12..8 from latch bits 4..0.
// - call/jump takes top two counter bits from latch bits 4..3.
// - eight-entry return stack, 13 bits each, outside all address spaces.
// - stack pointer has no register access at all.
// - call and interrupt vectoring push the return address.
// - return, return-with-literal and return-from-interrupt pop into counter.
// - push and pop leave the high latch unchanged.
// - stack is circular; ninth push overwrites the first entry.
// - no overflow or underflow flag; wrap is silent.
// - fetch overlaps execute; each branch is followed by two dead fetch cycles.
// - 14-bit instruction fetched over its own bus in one cycle.
package pcrs_pkg;

  // ==========================================================
  // widths
  localparam int PCRS_PC_W    = 13;
  localparam int PCRS_INSN_W  = 14;
  localparam int PCRS_DEPTH   = 8;
  localparam int PCRS_SP_W    = 3;

  // ==========================================================
  // register map (byte addresses on the bus)
  localparam logic [3:0] PCRS_OFF_LOW   = 4'h0;
  localparam logic [3:0] PCRS_OFF_LATCH = 4'h4;
  localparam logic [3:0] PCRS_OFF_STAT  = 4'h8;
  localparam logic [7:0] PCRS_LATCH_RST = 8'h00;
  localparam logic [12:0] PCRS_PC_RST   = 13'h0000;
  localparam logic [12:0] PCRS_VECTOR   = 13'h0004;

  // ==========================================================
  // field positions
  localparam int PCRS_LATCH_PAGE_LSB = 3;
  localparam int PCRS_JUMP_ADDR_W    = 11;

  // ==========================================================
  // sequencing events from decode
  typedef enum logic [2:0] {
    PCRS_OP_SEQ    = 3'h0,
    PCRS_OP_JUMP   = 3'h1,
    PCRS_OP_CALL   = 3'h2,
    PCRS_OP_RET    = 3'h3,
    PCRS_OP_RETLIT = 3'h4,
    PCRS_OP_RETINT = 3'h5,
    PCRS_OP_IRQ    = 3'h6
  } pcrs_op_t;

  typedef struct packed {
    pcrs_op_t    op;
    logic [10:0] target;
  } pcrs_ctl_t;

  // pipeline state, gray along run -> flush -> run
  typedef enum logic [0:0] {
    PCRS_ST_RUN   = 1'b0,
    PCRS_ST_FLUSH = 1'b1
  } pcrs_state_t;

endpackage : pcrs_pkg

// file: hdl/pcrs_core.sv
// program counter, high latch and circular return stack
`timescale 1ns/1ps
module pcrs_core
  import pcrs_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // decode side
  input  wire pcrs_ctl_t              ctl,
  input  wire logic                   ctl_valid,
  input  wire logic [PCRS_INSN_W-1:0] imem_rdata,
  output logic      [PCRS_PC_W-1:0]   imem_addr,
  output logic      [PCRS_INSN_W-1:0] insn,
  output logic                        insn_valid
);

  // ==========================================================
  // state
  logic [PCRS_PC_W-1:0] pc_reg, pc_next;
  logic [7:0]           latch_reg, latch_next;
  logic [PCRS_PC_W-1:0] stack_mem [PCRS_DEPTH];
  logic [PCRS_SP_W-1:0] sp_reg, sp_next;
  pcrs_state_t          st_reg, st_next;
  logic                 ack_reg;
  logic [31:0]          rdata_reg;
  logic [PCRS_INSN_W-1:0] insn_reg;
  logic                 ivalid_reg;

  function automatic logic [PCRS_PC_W-1:0] pc_inc(
    input logic [PCRS_PC_W-1:0] v);
    pc_inc = PCRS_PC_W'(v + 13'h0001);
  endfunction : pc_inc

  // ==========================================================
  // bus decode: one wait state, every access acked
  wire bus_req    = (avs_read | avs_write) & ~ack_reg;
  wire wr_low     = bus_req & avs_write & (avs_address == PCRS_OFF_LOW);
  wire wr_latch   = bus_req & avs_write & (avs_address == PCRS_OFF_LATCH);
  wire is_op      = ctl_valid & (st_reg == PCRS_ST_RUN);
  wire do_push    = is_op & (ctl.op == PCRS_OP_CALL ||
                             ctl.op == PCRS_OP_IRQ);
  wire do_pop     = is_op & (ctl.op == PCRS_OP_RET ||
                             ctl.op == PCRS_OP_RETLIT ||
                             ctl.op == PCRS_OP_RETINT);
  wire do_jump    = is_op & (ctl.op == PCRS_OP_JUMP ||
                             ctl.op == PCRS_OP_CALL);
  wire do_irq     = is_op & (ctl.op == PCRS_OP_IRQ);
  wire [PCRS_SP_W-1:0] sp_top = PCRS_SP_W'(sp_reg - 3'h1);
  // page bits from latch, rest from the instruction field
  wire [PCRS_PC_W-1:0] jump_pc =
    {latch_reg[4:PCRS_LATCH_PAGE_LSB], ctl.target};
  // low write: upper bits from latch 4..0, pointer wrap unflagged
  wire [PCRS_PC_W-1:0] low_pc =
    {latch_reg[4:0], avs_writedata[7:0]};
  wire redirect   = wr_low | do_jump | do_pop | do_irq;

  wire [31:0] rd_mux =
    (avs_address == PCRS_OFF_LOW)   ? {24'h000000, pc_reg[7:0]} :
    (avs_address == PCRS_OFF_LATCH) ? {24'h000000, latch_reg} :
    (avs_address == PCRS_OFF_STAT)  ? {31'h00000000, st_reg} :
                                      32'h00000000;

  // ==========================================================
  // next-state
  always_comb begin
    pc_next    = pc_reg;
    sp_next    = sp_reg;
    st_next    = PCRS_ST_RUN;
    latch_next = wr_latch ? avs_writedata[7:0] : latch_reg;
    // bus write to the low byte wins over a decode event
    if (wr_low) begin
      pc_next = low_pc;
    end else if (do_irq) begin
      pc_next = PCRS_VECTOR;
    end else if (do_jump) begin
      pc_next = jump_pc;
    end else if (do_pop) begin
      pc_next = stack_mem[sp_top];
    end else begin
      pc_next = pc_inc(pc_reg);
    end
    if (do_push & ~wr_low) begin
      sp_next = PCRS_SP_W'(sp_reg + 3'h1);
    end else if (do_pop & ~wr_low) begin
      sp_next = sp_top;
    end
    if (redirect) begin
      st_next = PCRS_ST_FLUSH;
    end
    case (st_reg)
      PCRS_ST_RUN:   ;
      PCRS_ST_FLUSH: ;
      default:       st_next = PCRS_ST_RUN;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_reg    <= PCRS_PC_RST;
      latch_reg <= PCRS_LATCH_RST;
      sp_reg    <= '0;
      st_reg    <= PCRS_ST_RUN;
    end else begin
      pc_reg    <= pc_next;
      latch_reg <= latch_next;
      sp_reg    <= sp_next;
      st_reg    <= st_next;
    end
  end

  // return address is the already-incremented fetch address
  always_ff @(posedge mclk) begin
    if (do_push & ~wr_low) begin
      stack_mem[sp_reg] <= pc_reg;
    end
  end

  // fetched words are dropped in the two cycles after a redirect
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      insn_reg   <= '0;
      ivalid_reg <= 1'b0;
    end else begin
      insn_reg   <= imem_rdata;
      ivalid_reg <= ~redirect & (st_reg == PCRS_ST_RUN);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= bus_req;
      rdata_reg <= rd_mux;
    end
  end

  assign imem_addr       = pc_reg;
  assign insn            = insn_reg;
  assign insn_valid      = ivalid_reg;
  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = ~ack_reg;

  // ==========================================================
  // checks
  AST_RESET_PC: assert property (@(posedge mclk)
    $rose(rst_b) |-> pc_reg == PCRS_PC_RST)
    else $error("counter not cleared by reset");

  AST_LOW_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_low |=> pc_reg == {$past(latch_reg[4:0]), $past(avs_writedata[7:0])})
    else $error("low write did not load page from latch");

  AST_JUMP_PAGE: assert property (@(posedge mclk) disable iff (!rst_b)
    (do_jump & ~wr_low & ~do_irq) |=> pc_reg[12:11] == $past(latch_reg[4:3]))
    else $error("jump page bits wrong");

  AST_SEQ_INC: assert property (@(posedge mclk) disable iff (!rst_b)
    ~redirect |=> pc_reg == pc_inc($past(pc_reg)))
    else $error("counter did not increment");

  // pushed word lands at the old pointer, popped word from the old top
  AST_PUSH_STORE: assert property (@(posedge mclk) disable iff (!rst_b)
    (do_push & ~wr_low) |=> stack_mem[$past(sp_reg)] == $past(pc_reg))
    else $error("push did not store return address");

  AST_PUSH_POP: assert property (@(posedge mclk) disable iff (!rst_b)
    (do_pop & ~wr_low) |=> pc_reg == $past(stack_mem[sp_top]))
    else $error("pop did not load top entry");

  AST_LATCH_KEEP: assert property (@(posedge mclk) disable iff (!rst_b)
    ((do_push | do_pop) & ~wr_latch) |=> $stable(latch_reg))
    else $error("stack op changed latch");

  AST_SP_WRAP: assert property (@(posedge mclk) disable iff (!rst_b)
    (do_push & ~wr_low & sp_reg == 3'h7) |=> sp_reg == 3'h0)
    else $error("stack pointer did not wrap");

  AST_FLUSH: assert property (@(posedge mclk) disable iff (!rst_b)
    redirect |=> !insn_valid ##1 !insn_valid)
    else $error("fetched word not flushed");

  AST_BUS_ACK: assert property (@(posedge mclk) disable iff (!rst_b)
    bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

  // ==========================================================
  // further checks on vectoring, pointer, latch, fetch, flush and read path
  AST_IRQ_VECTOR: assert property (@(posedge mclk) disable iff (!rst_b)
    (do_irq & ~wr_low) |=> pc_reg == PCRS_VECTOR)
    else $error("interrupt did not reach the vector");

  AST_PUSH_SP: assert property (@(posedge mclk) disable iff (!rst_b)
    (do_push & ~wr_low) |=> sp_reg == PCRS_SP_W'($past(sp_reg) + 3'h1))
    else $error("push did not advance pointer");

  AST_POP_SP: assert property (@(posedge mclk) disable iff (!rst_b)
    (do_pop & ~wr_low) |=> sp_reg == $past(sp_top))
    else $error("pop did not retreat pointer");

  // a low-byte write drops the event, so the pointer must hold
  AST_LOW_WINS: assert property (@(posedge mclk) disable iff (!rst_b)
    (wr_low & (do_push | do_pop)) |=> $stable(sp_reg))
    else $error("dropped event moved the pointer");

  AST_LATCH_WRITE: assert property (@(posedge mclk) disable iff (!rst_b)
    wr_latch |=> latch_reg == $past(avs_writedata[7:0]))
    else $error("latch write lost");

  AST_INSN_PIPE: assert property (@(posedge mclk) disable iff (!rst_b)
    1'b1 |=> insn == $past(imem_rdata))
    else $error("fetched word not registered");

  AST_ONE_FLUSH: assert property (@(posedge mclk) disable iff (!rst_b)
    (st_reg == PCRS_ST_FLUSH & ~redirect) |=> st_reg == PCRS_ST_RUN)
    else $error("flush lasted too long");

  AST_READ_LOW: assert property (@(posedge mclk) disable iff (!rst_b)
    (bus_req & avs_read & avs_address == PCRS_OFF_LOW)
      |=> avs_readdata == {24'h000000, $past(pc_reg[7:0])})
    else $error("low byte read wrong");

  AST_READ_UPPER: assert property (@(posedge mclk) disable iff (!rst_b)
    (bus_req & avs_read) |=> avs_readdata[31:8] == 24'h000000)
    else $error("read upper bits not zero");

  AST_RESET_VALID: assert property (@(posedge mclk)
    $rose(rst_b) |-> !insn_valid)
    else $error("fetch valid right after reset");

endmodule : pcrs_core

// file: dv/pcrs_imem_model.sv
// program memory model standing in for the fetch side of the core
`timescale 1ns/1ps
module pcrs_imem_model
  import pcrs_pkg::*;
(
  addr,
  rdata
);
  input  wire logic [PCRS_PC_W-1:0]   addr;
  output logic      [PCRS_INSN_W-1:0] rdata;
  // word scrambled from its own address so a misfetch shows
  assign rdata = {1'b1, addr ^ 13'h0a5a};
endmodule : pcrs_imem_model

// file: dv/pcrs_core_tb_top.sv
// self-checking bench for the program counter and return stack
`timescale 1ns/1ps
module pcrs_core_tb_top
  import pcrs_pkg::*;
;
  logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  pcrs_ctl_t   ctl;
  logic        ctl_valid, insn_valid;
  logic [13:0] imem_rdata, insn;
  logic [12:0] imem_addr, last_pc, a;
  logic [12:0] rec [0:8];
  int          miscompares = 0;
  int          cmp_count = 0;

  pcrs_core DUT (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ctl(ctl), .ctl_valid(ctl_valid),
    .imem_rdata(imem_rdata), .imem_addr(imem_addr), .insn(insn),
    .insn_valid(insn_valid));
  pcrs_imem_model imem (.addr(imem_addr), .rdata(imem_rdata));

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [3:0] ad,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= ad;
    avs_writedata <= {24'h000000, d};
    avs_write     <= w;
    avs_read      <= !w;
    // hold until waitrequest seen low at an edge
    // sample mid-cycle; the answer stands through the next rising edge
    do begin
      @(negedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    @(posedge mclk);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) miscompares++;
  endtask : bus

  task automatic ev(input pcrs_op_t op, input logic [10:0] t,
                    input logic [12:0] e);
    int n;
    n = 0;
    // never issue inside a flush cycle, it would be dropped
    do begin
      @(negedge mclk);
      n++;
    end while (insn_valid !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    @(posedge mclk);
    ctl       <= '{op: op, target: t};
    ctl_valid <= 1'b1;
    @(negedge mclk);
    last_pc = imem_addr;
    @(posedge mclk);
    ctl_valid <= 1'b0;
    @(negedge mclk);
    chk(imem_addr, e);
    chk(insn_valid, 1'b0);
    @(negedge mclk);
    chk(insn_valid, 1'b0);
    @(negedge mclk);
    chk(insn_valid, 1'b1);
  endtask : ev

  task automatic test_done;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk(imem_addr, PCRS_PC_RST);
    bus(1'b0, PCRS_OFF_LATCH, 8'h00);
    chk(q, 32'h0);
    bus(1'b0, 4'hc, 8'h00);
    chk(q, 32'h0);
    $display("reset done");
  endtask : t_reset

  task automatic t_seq;
    @(posedge mclk);
    #1 a = imem_addr;
    @(posedge mclk);
    #1 chk(imem_addr, a + 13'h0001);
    chk(insn, {1'b1, a ^ 13'h0a5a});
    bus(1'b1, PCRS_OFF_LATCH, 8'h02);
    bus(1'b1, PCRS_OFF_LOW, 8'hfe);
    #1 chk(imem_addr[12:8], 5'h02);
    repeat (6) @(posedge mclk);
    #1 chk(imem_addr[12:8], 5'h03);
    bus(1'b0, PCRS_OFF_LATCH, 8'h00);
    chk(q, 32'h02);
    $display("sequential done");
  endtask : t_seq

  task automatic t_stack;
    bus(1'b1, PCRS_OFF_LATCH, 8'h18);
    ev(PCRS_OP_JUMP, 11'h123, 13'h1923);
    bus(1'b1, PCRS_OFF_LATCH, 8'h05);
    ev(PCRS_OP_IRQ, 11'h000, PCRS_VECTOR);
    ev(PCRS_OP_RETINT, 11'h000, last_pc);
    for (int i = 0; i < 9; i++) begin
      ev(PCRS_OP_CALL, 11'(i * 16 + 1), 13'(i * 16 + 1));
      rec[i] = last_pc;
    end
    // ninth push overwrote the first; ninth pop wraps back onto it
    for (int k = 0; k < 9; k++)
      ev(pcrs_op_t'(3 + k % 3), 11'h000, rec[k == 8 ? 8 : 8 - k]);
    bus(1'b0, PCRS_OFF_LATCH, 8'h00);
    chk(q, 32'h05);
    $display("stack done");
  endtask : t_stack

  task automatic t_rerst;
    bus(1'b1, PCRS_OFF_LATCH, 8'h1f);
    @(posedge mclk);
    rst_b <= 1'b0;
    @(negedge mclk);
    chk(imem_addr, PCRS_PC_RST);
    chk(insn_valid, 1'b0);
    @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk(imem_addr, PCRS_PC_RST);
    bus(1'b0, PCRS_OFF_LATCH, 8'h00);
    chk(q, 32'h0);
    $display("second reset done");
  endtask : t_rerst

  // ==========================================================
  // clock, reset, sequence, watchdog
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    rst_b = 1'b0;
    {avs_read, avs_write, ctl_valid} = 3'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    ctl = '{op: PCRS_OP_SEQ, target: 11'h000};
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_seq();
    t_stack();
    t_rerst();
    test_done();
  end

  initial begin
    #20000;
    miscompares++;
    test_done();
  end
endmodule : pcrs_core_tb_top
